// ==== shared/sbx_pkg.sv ====
/*
  sbx_pkg: register offsets, field positions, reset values and state codes
  for the storage bridge transfer-control slice.
  Assumes an 8-bit register port with 16-bit byte addresses.
*/
package sbx_pkg;

  // register byte addresses
  localparam logic [15:0] SBX_ADDR_COUNT0 = 16'hF0D6;
  localparam logic [15:0] SBX_ADDR_COUNT1 = 16'hF0D7;
  localparam logic [15:0] SBX_ADDR_COUNT2 = 16'hF0D8;
  localparam logic [15:0] SBX_ADDR_COUNT3 = 16'hF0D9;
  localparam logic [15:0] SBX_ADDR_PKTLEN = 16'hF0DA;
  localparam logic [15:0] SBX_ADDR_CONFIG = 16'hF0E0;
  localparam logic [15:0] SBX_ADDR_STATE  = 16'hF0E1;

  // packet_length_and_bus_ctrl fields
  localparam int          SBX_PKT_LEN_LSB = 0;
  localparam int          SBX_PKT_LEN_W   = 5;
  localparam int          SBX_DISABLE_BIT = 5;
  localparam int          SBX_ABORT_BIT   = 6;

  // drive_if_config1 fields
  localparam int          SBX_CFG_AUTO_CMD = 0;
  localparam int          SBX_CFG_DRIVE_HARD_RESET = 1;
  localparam int          SBX_CFG_CNT_SEL  = 2;
  localparam int          SBX_CFG_PKT_DRV  = 3;
  localparam int          SBX_CFG_MODE_LSB = 4;

  // reset values
  localparam logic [7:0]  SBX_COUNT_RST   = 8'h00;
  localparam logic [4:0]  SBX_PKT_LEN_RST = 5'h00;
  localparam logic        SBX_DISABLE_RST = 1'b1;
  localparam logic        SBX_ABORT_RST   = 1'b0;
  localparam logic [7:0]  SBX_CONFIG_RST  = 8'h00;

  // task-file entry ranges
  localparam logic [3:0]  SBX_PKT_FIRST_IDX = 4'h0;
  localparam logic [4:0]  SBX_PKT_MAX_LEN   = 5'h10;
  localparam logic [3:0]  SBX_ATA_FIRST_IDX = 4'h1;
  localparam logic [3:0]  SBX_ATA_LAST_IDX  = 4'h7;

  // transfer modes
  typedef enum logic [1:0]
  {
    SBX_MODE_MANUAL = 2'h0,
    SBX_MODE_SEMI   = 2'h1,
    SBX_MODE_FULL   = 2'h2
  } sbx_mode_type;

  // transaction states, idle reads as zero
  typedef enum logic [2:0]
  {
    SBX_ST_IDLE = 3'h0,
    SBX_ST_CMD  = 3'h1,
    SBX_ST_DATA = 3'h2
  } sbx_state_type;

endpackage : sbx_pkg

// ==== core/sbx_cmd_seq.sv ====
/*
  sbx_cmd_seq: walks task-file entries and emits one write pulse per byte
  of the command phase. Assumes the task file answers an index in the
  same cycle and that drive_ready is already synchronised.
*/
`timescale 1ns/1ps
module sbx_cmd_seq
(
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       nrst,
  input  wire logic       clk_en,
  // control
  input  wire logic       start,
  input  wire logic       abort,
  input  wire logic       packet_mode,
  input  wire logic [4:0] packet_byte_length,
  input  wire logic       drive_ready,
  // results
  output logic      [3:0] task_file_entry,
  output logic            byte_write,
  output logic            done
);

  logic       active_reg;
  logic [3:0] idx_reg;
  logic [3:0] last_reg;
  logic       empty_reg;

  // cap the packet at sixteen entries; zero length sends nothing
  function automatic logic [3:0] sbx_last_entry(input logic [4:0] len);
    if (len >= sbx_pkg::SBX_PKT_MAX_LEN)
      return 4'hF;
    else
      return len[3:0] - 4'h1;
  endfunction : sbx_last_entry

  assign task_file_entry = idx_reg;
  assign byte_write      = active_reg && !empty_reg && drive_ready && !abort;
  assign done            = active_reg && (empty_reg || (byte_write && idx_reg == last_reg));

  // sequence position
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      active_reg <= 1'b0;
      idx_reg    <= 4'h0;
      last_reg   <= 4'h0;
      empty_reg  <= 1'b0;
    end
    else if (clk_en)
    begin
      if (abort || done)
        active_reg <= 1'b0;
      else if (start)
      begin
        active_reg <= 1'b1;
        if (packet_mode)
        begin
          idx_reg   <= sbx_pkg::SBX_PKT_FIRST_IDX;
          last_reg  <= sbx_last_entry(packet_byte_length);
          empty_reg <= (packet_byte_length == 5'h00);
        end
        else
        begin
          idx_reg   <= sbx_pkg::SBX_ATA_FIRST_IDX;
          last_reg  <= sbx_pkg::SBX_ATA_LAST_IDX;
          empty_reg <= 1'b0;
        end
      end
      else if (byte_write)
        idx_reg <= idx_reg + 4'h1;
    end
  end

endmodule : sbx_cmd_seq

// ==== core/sbx_xfer_ctrl.sv ====
/*
  sbx_xfer_ctrl: transfer byte count top byte, command packet length,
  drive bus output disable and firmware abort for the drive-side
  transaction sequencer, with the two 32-bit transfer count copies.
  Assumes a single core clock, an 8-bit register port answered one
  cycle after a read strobe, and drive pins resolved outside.
*/
`timescale 1ns/1ps
module sbx_xfer_ctrl
#(
  parameter int DEC_W = 16
)
(
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             nrst,
  input  wire logic             clk_en,
  // register port
  input  wire logic [15:0]      reg_addr,
  input  wire logic [7:0]       reg_wdata,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  output logic      [7:0]       reg_rdata,
  // transfer requests and count traffic
  input  wire logic             xfer_start,
  input  wire logic             host_dec_valid,
  input  wire logic [DEC_W-1:0] host_dec_bytes,
  input  wire logic             drive_dec_valid,
  input  wire logic [DEC_W-1:0] drive_dec_bytes,
  // task file
  output logic      [3:0]       task_file_entry,
  input  wire logic [7:0]       task_file_data,
  // drive-side pins
  input  wire logic             drive_ready_pin,
  output logic      [7:0]       drive_data_out,
  output logic                  drive_data_oe,
  output logic                  drive_wr_n_out,
  output logic                  drive_wr_n_oe,
  output logic                  drive_reset_pin_n_out,
  output logic                  drive_reset_pin_n_oe,
  // status
  output logic      [4:0]       transaction_state,
  output logic      [31:0]      host_count,
  output logic      [31:0]      drive_count
);

  sbx_pkg::sbx_state_type state_reg;
  sbx_pkg::sbx_state_type state_next;

  logic [31:0] host_count_reg;
  logic [31:0] drive_count_reg;
  logic [4:0]  packet_byte_length_reg;
  logic        drive_bus_output_disable_reg;
  logic        xfer_abort_request_reg;
  logic [7:0]  drive_if_config1_reg;
  logic [7:0]  reg_rdata_reg;
  logic [7:0]  drive_data_reg;
  logic        drive_wr_n_reg;
  logic [2:0]  ready_sync_reg;
  logic        drive_ready_reg;

  logic        auto_cmd_mode;
  logic        drive_hard_reset;
  logic        count_read_select;
  logic        packet_drive;
  sbx_pkg::sbx_mode_type xfer_mode;
  logic        auto_xfer;
  logic        abort_now;
  logic        seq_start;
  logic        seq_write;
  logic        seq_done;
  logic [3:0]  count_wr;
  logic [31:0] count_sel;

  // byte lane of a count write, one-hot over the four count bytes
  function automatic logic [3:0] sbx_count_lane(input logic [15:0] addr, input logic wr);
    logic [3:0] lane;
    lane    = 4'h0;
    lane[0] = wr && (addr == sbx_pkg::SBX_ADDR_COUNT0);
    lane[1] = wr && (addr == sbx_pkg::SBX_ADDR_COUNT1);
    lane[2] = wr && (addr == sbx_pkg::SBX_ADDR_COUNT2);
    lane[3] = wr && (addr == sbx_pkg::SBX_ADDR_COUNT3);
    return lane;
  endfunction : sbx_count_lane

  // saturating decrement so a count mismatch cannot wrap to a huge value
  function automatic logic [31:0] sbx_count_dec(input logic [31:0] cnt,
                                                input logic [DEC_W-1:0] amt);
    logic [31:0] wide;
    wide = 32'(amt);
    if (wide >= cnt)
      return 32'h0000_0000;
    else
      return cnt - wide;
  endfunction : sbx_count_dec

  // load selected bytes of a copy from the write data
  function automatic logic [31:0] sbx_count_load(input logic [31:0] cnt,
                                                 input logic [3:0] lane,
                                                 input logic [7:0] data);
    logic [31:0] res;
    res = cnt;
    for (int i = 0; i < 4; i++)
      if (lane[i])
        res[i*8 +: 8] = data;
    return res;
  endfunction : sbx_count_load

  // configuration field decode
  assign auto_cmd_mode     = drive_if_config1_reg[sbx_pkg::SBX_CFG_AUTO_CMD];
  assign drive_hard_reset  = drive_if_config1_reg[sbx_pkg::SBX_CFG_DRIVE_HARD_RESET];
  assign count_read_select = drive_if_config1_reg[sbx_pkg::SBX_CFG_CNT_SEL];
  assign packet_drive      = drive_if_config1_reg[sbx_pkg::SBX_CFG_PKT_DRV];
  assign xfer_mode         = sbx_pkg::sbx_mode_type'(
                               drive_if_config1_reg[sbx_pkg::SBX_CFG_MODE_LSB +: 2]);
  assign auto_xfer         = (xfer_mode == sbx_pkg::SBX_MODE_SEMI) ||
                             (xfer_mode == sbx_pkg::SBX_MODE_FULL);
  assign count_wr          = sbx_count_lane(reg_addr, reg_wr);

  assign abort_now = xfer_abort_request_reg && auto_xfer && (state_reg != sbx_pkg::SBX_ST_IDLE);
  assign seq_start = (state_reg == sbx_pkg::SBX_ST_IDLE) && (state_next == sbx_pkg::SBX_ST_CMD);

  // count byte three and the lower count bytes
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      host_count_reg  <= {4{sbx_pkg::SBX_COUNT_RST}};
      drive_count_reg <= {4{sbx_pkg::SBX_COUNT_RST}};
    end
    else if (clk_en)
    begin
      if (|count_wr)
      begin
        host_count_reg  <= sbx_count_load(host_count_reg, count_wr, reg_wdata);
        drive_count_reg <= sbx_count_load(drive_count_reg, count_wr, reg_wdata);
      end
      else
      begin
        if (host_dec_valid)
          host_count_reg <= sbx_count_dec(host_count_reg, host_dec_bytes);
        if (drive_dec_valid)
          drive_count_reg <= sbx_count_dec(drive_count_reg, drive_dec_bytes);
      end
    end
  end

  // packet length, bus disable and abort fields
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      packet_byte_length_reg       <= sbx_pkg::SBX_PKT_LEN_RST;
      drive_bus_output_disable_reg <= sbx_pkg::SBX_DISABLE_RST;
      xfer_abort_request_reg       <= sbx_pkg::SBX_ABORT_RST;
    end
    else if (clk_en && reg_wr && reg_addr == sbx_pkg::SBX_ADDR_PKTLEN)
    begin
      packet_byte_length_reg       <= reg_wdata[sbx_pkg::SBX_PKT_LEN_LSB +: sbx_pkg::SBX_PKT_LEN_W];
      drive_bus_output_disable_reg <= reg_wdata[sbx_pkg::SBX_DISABLE_BIT];
      xfer_abort_request_reg       <= reg_wdata[sbx_pkg::SBX_ABORT_BIT];
    end
  end

  // interface configuration
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      drive_if_config1_reg <= sbx_pkg::SBX_CONFIG_RST;
    else if (clk_en && reg_wr && reg_addr == sbx_pkg::SBX_ADDR_CONFIG)
      drive_if_config1_reg <= reg_wdata;
  end

  assign count_sel = count_read_select ? drive_count_reg : host_count_reg;

  // read data registered, valid only in the cycle after the strobe
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      reg_rdata_reg <= 8'h00;
    else if (clk_en)
    begin
      reg_rdata_reg <= 8'h00;
      if (reg_rd)
      begin
        unique case (reg_addr)
          sbx_pkg::SBX_ADDR_COUNT0: reg_rdata_reg <= count_sel[7:0];
          sbx_pkg::SBX_ADDR_COUNT1: reg_rdata_reg <= count_sel[15:8];
          sbx_pkg::SBX_ADDR_COUNT2: reg_rdata_reg <= count_sel[23:16];
          sbx_pkg::SBX_ADDR_COUNT3: reg_rdata_reg <= count_sel[31:24];
          sbx_pkg::SBX_ADDR_PKTLEN: reg_rdata_reg <= {1'b0, xfer_abort_request_reg,
                                                      drive_bus_output_disable_reg,
                                                      packet_byte_length_reg};
          sbx_pkg::SBX_ADDR_CONFIG: reg_rdata_reg <= drive_if_config1_reg;
          sbx_pkg::SBX_ADDR_STATE:  reg_rdata_reg <= {3'h0, transaction_state};
          default:                  reg_rdata_reg <= 8'h00;
        endcase
      end
    end
  end

  // ready pin: three flops, a change counts once stages two and three agree
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      ready_sync_reg  <= 3'h0;
      drive_ready_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      ready_sync_reg <= {ready_sync_reg[1:0], drive_ready_pin};
      if (ready_sync_reg[1] == ready_sync_reg[2])
        drive_ready_reg <= ready_sync_reg[2];
    end
  end

  // transaction sequencer next state
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      sbx_pkg::SBX_ST_IDLE:
      begin
        if (xfer_start && !xfer_abort_request_reg)
        begin
          // command phase only with automatic command
          if (xfer_mode == sbx_pkg::SBX_MODE_FULL && auto_cmd_mode)
            state_next = sbx_pkg::SBX_ST_CMD;
          else if (xfer_mode == sbx_pkg::SBX_MODE_SEMI || xfer_mode == sbx_pkg::SBX_MODE_FULL)
            state_next = sbx_pkg::SBX_ST_DATA;
        end
      end
      sbx_pkg::SBX_ST_CMD:
      begin
        if (seq_done)
          state_next = sbx_pkg::SBX_ST_DATA;
      end
      sbx_pkg::SBX_ST_DATA:
      begin
        if (drive_count_reg == 32'h0000_0000)
          state_next = sbx_pkg::SBX_ST_IDLE;
      end
      default: state_next = sbx_pkg::SBX_ST_IDLE;
    endcase
    if (abort_now)
      state_next = sbx_pkg::SBX_ST_IDLE;
  end

  // state register; the disable bit never enters here
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      state_reg <= sbx_pkg::SBX_ST_IDLE;
    else if (clk_en)
      state_reg <= state_next;
  end

  // command packet byte sequencer
  sbx_cmd_seq u_cmd_seq
  (
    .core_clk           (core_clk),
    .nrst               (nrst),
    .clk_en             (clk_en),
    .start              (seq_start),
    .abort              (abort_now),
    .packet_mode        (packet_drive),
    .packet_byte_length (packet_byte_length_reg),
    .drive_ready        (drive_ready_reg),
    .task_file_entry    (task_file_entry),
    .byte_write         (seq_write),
    .done               (seq_done)
  );

  // drive data and write strobe come from flops
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      drive_data_reg <= 8'h00;
      drive_wr_n_reg <= 1'b1;
    end
    else if (clk_en)
    begin
      drive_wr_n_reg <= !(seq_write && state_reg == sbx_pkg::SBX_ST_CMD);
      if (seq_write && state_reg == sbx_pkg::SBX_ST_CMD)
        drive_data_reg <= task_file_data;
    end
  end

  assign drive_data_out = drive_data_reg;
  assign drive_wr_n_out = drive_wr_n_reg;
  assign drive_data_oe  = !drive_bus_output_disable_reg;
  assign drive_wr_n_oe  = !drive_bus_output_disable_reg;
  assign drive_reset_pin_n_out = !drive_hard_reset;
  assign drive_reset_pin_n_oe  = drive_hard_reset || !drive_bus_output_disable_reg;

  // status outputs
  assign reg_rdata         = reg_rdata_reg;
  assign transaction_state = {2'h0, state_reg};
  assign host_count        = host_count_reg;
  assign drive_count       = drive_count_reg;

endmodule : sbx_xfer_ctrl

// ==== bench/sbx_xfer_ctrl_props.sv ====
/*
  sbx_xfer_ctrl_props: port-level checks for the transfer-control slice.
  Assumes one core clock and a synchronous active-low reset.
*/
`timescale 1ns/1ps
module sbx_xfer_ctrl_props
#(
  parameter int DEC_W = 16
)
(
  input wire logic             core_clk,
  input wire logic             nrst,
  input wire logic             clk_en,
  input wire logic [15:0]      reg_addr,
  input wire logic [7:0]       reg_wdata,
  input wire logic             reg_wr,
  input wire logic             reg_rd,
  input wire logic [7:0]       reg_rdata,
  input wire logic             host_dec_valid,
  input wire logic [DEC_W-1:0] host_dec_bytes,
  input wire logic             drive_data_oe,
  input wire logic             drive_wr_n_oe,
  input wire logic             drive_reset_pin_n_out,
  input wire logic             drive_reset_pin_n_oe,
  input wire logic [4:0]       transaction_state,
  input wire logic [31:0]      host_count,
  input wire logic [31:0]      drive_count
);
  logic abort_reg;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  // shadow of the abort bit, taken from firmware writes
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      abort_reg <= 1'b0;
    else if (clk_en && reg_wr && reg_addr == sbx_pkg::SBX_ADDR_PKTLEN)
      abort_reg <= reg_wdata[sbx_pkg::SBX_ABORT_BIT];
  end
  property p_reset; !$past(nrst) |-> host_count == 32'h0 && !drive_data_oe; endproperty
  a_reset: assert property (p_reset) else $error("reset values wrong");
  property p_count3; clk_en && reg_wr && reg_addr == sbx_pkg::SBX_ADDR_COUNT3 |=>
    host_count[31:24] == $past(reg_wdata) && drive_count[31:24] == $past(reg_wdata); endproperty
  a_count3: assert property (p_count3) else $error("count byte three not loaded");
  property p_oe_pair; drive_data_oe == drive_wr_n_oe; endproperty
  a_oe_pair: assert property (p_oe_pair) else $error("drive enables differ");
  property p_dis_oe; clk_en && reg_wr && reg_addr == sbx_pkg::SBX_ADDR_PKTLEN |=>
    drive_data_oe == !$past(reg_wdata[5]); endproperty
  a_dis_oe: assert property (p_dis_oe) else $error("disable bit not applied");
  property p_rst_pin; !drive_reset_pin_n_out |-> drive_reset_pin_n_oe; endproperty
  a_rst_pin: assert property (p_rst_pin) else $error("reset pin low but floating");
  property p_rd_stand; $past(clk_en) && !$past(reg_rd) |-> reg_rdata == 8'h00; endproperty
  a_rd_stand: assert property (p_rd_stand) else $error("read data outside slot");
  property p_abort_idle; abort_reg && transaction_state != 5'h00 |=>
    transaction_state == 5'h00; endproperty
  a_abort_idle: assert property (p_abort_idle) else $error("abort did not idle");
  property p_abort_hold; abort_reg && transaction_state == 5'h00 |=>
    transaction_state == 5'h00; endproperty
  a_abort_hold: assert property (p_abort_hold) else $error("left idle under abort");
  property p_host_dec; clk_en && host_dec_valid && !reg_wr &&
    host_count >= 32'(host_dec_bytes) |=>
    host_count == $past(host_count) - 32'($past(host_dec_bytes)); endproperty
  a_host_dec: assert property (p_host_dec) else $error("host count decrement wrong");
endmodule : sbx_xfer_ctrl_props
bind sbx_xfer_ctrl sbx_xfer_ctrl_props #(.DEC_W(DEC_W)) props_u
(
  .core_clk              (core_clk),
  .nrst                  (nrst),
  .clk_en                (clk_en),
  .reg_addr              (reg_addr),
  .reg_wdata             (reg_wdata),
  .reg_wr                (reg_wr),
  .reg_rd                (reg_rd),
  .reg_rdata             (reg_rdata),
  .host_dec_valid        (host_dec_valid),
  .host_dec_bytes        (host_dec_bytes),
  .drive_data_oe         (drive_data_oe),
  .drive_wr_n_oe         (drive_wr_n_oe),
  .drive_reset_pin_n_out (drive_reset_pin_n_out),
  .drive_reset_pin_n_oe  (drive_reset_pin_n_oe),
  .transaction_state     (transaction_state),
  .host_count            (host_count),
  .drive_count           (drive_count)
);

// ==== bench/sbx_drive_model.sv ====
/*
  sbx_drive_model: drive-side partner that counts command bytes and
  answers with a ready level. Assumes the bridge's split pin ports.
*/
`timescale 1ns/1ps
module sbx_drive_model
(
  // clock and control
  input  wire logic       core_clk,
  input  wire logic       clr,
  input  wire logic       slow,
  // bridge pins
  input  wire logic [7:0] drive_data_out,
  input  wire logic       drive_data_oe,
  input  wire logic       drive_wr_n_out,
  input  wire logic       drive_wr_n_oe,
  output logic            drive_ready_pin,
  // captured command bytes
  output logic      [7:0] rx_bytes [0:15],
  output logic      [5:0] n_rx
);
  logic [3:0] cyc_reg = 4'h0;
  // a slow drive drops ready eight cycles in sixteen, long enough to pass the filter
  always_ff @(posedge core_clk) cyc_reg <= cyc_reg + 4'h1;
  assign drive_ready_pin = slow ? cyc_reg[3] : 1'b1;
  // a strobe on a floating bus is not seen; extra bytes are counted but not kept
  always_ff @(posedge core_clk)
  begin
    if (clr)
      n_rx <= 6'h00;
    else if (!drive_wr_n_out && drive_wr_n_oe && drive_data_oe)
    begin
      if (n_rx < 6'h10)
        rx_bytes[n_rx[3:0]] <= drive_data_out;
      n_rx <= n_rx + 6'h01;
    end
  end
endmodule : sbx_drive_model

// ==== bench/sbx_xfer_ctrl_test.sv ====
/*
  sbx_xfer_ctrl_test: directed bench for the transfer-control slice.
  Assumes the drive model beside it and a task file echoing its index.
*/
`timescale 1ns/1ps
module sbx_xfer_ctrl_test;
  logic        core_clk, nrst, reg_wr, reg_rd, xfer_start, clr, slow;
  logic        host_dec_valid, drive_dec_valid, ready, d_oe, w_oe, wr_n;
  logic        rp_out, rp_oe, clk_en;
  logic [15:0] reg_addr, host_dec_bytes, drive_dec_bytes;
  logic [7:0]  reg_wdata, reg_rdata, d_out, rd_d;
  logic [7:0]  rx_bytes [0:15];
  logic [5:0]  n_rx;
  logic [4:0]  st;
  logic [3:0]  tf_idx;
  logic [31:0] h_cnt, d_cnt;
  int          errors = 0;
  int          n_tests = 0;
  // task file byte is its index with a marker nibble
  wire  [7:0]  tf_data = {4'h5, tf_idx};
  sbx_xfer_ctrl dut_u (.core_clk(core_clk), .nrst(nrst), .clk_en(clk_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .xfer_start(xfer_start), .host_dec_valid(host_dec_valid),
    .host_dec_bytes(host_dec_bytes), .drive_dec_valid(drive_dec_valid),
    .drive_dec_bytes(drive_dec_bytes), .task_file_entry(tf_idx), .task_file_data(tf_data),
    .drive_ready_pin(ready), .drive_data_out(d_out), .drive_data_oe(d_oe),
    .drive_wr_n_out(wr_n), .drive_wr_n_oe(w_oe), .drive_reset_pin_n_out(rp_out),
    .drive_reset_pin_n_oe(rp_oe), .transaction_state(st), .host_count(h_cnt),
    .drive_count(d_cnt));
  sbx_drive_model drv_u (.core_clk(core_clk), .clr(clr), .slow(slow),
    .drive_data_out(d_out), .drive_data_oe(d_oe), .drive_wr_n_out(wr_n),
    .drive_wr_n_oe(w_oe), .drive_ready_pin(ready), .rx_bytes(rx_bytes), .n_rx(n_rx));
  // free-running core clock
  initial
  begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR %0t %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    #1;
  endtask : wr
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd
  task automatic start;
    @(posedge core_clk);
    xfer_start <= 1'b1;
    @(posedge core_clk);
    xfer_start <= 1'b0;
    #1;
  endtask : start
  task automatic t_reset_values;
    rd(sbx_pkg::SBX_ADDR_COUNT3, rd_d);
    chk(rd_d, 8'h00, "count3 reset");
    rd(sbx_pkg::SBX_ADDR_PKTLEN, rd_d);
    chk(rd_d, 8'h20, "pktlen reset");
    chk(d_oe, 1'b0, "bus floats at reset");
    rd(16'hF0FF, rd_d);
    chk(rd_d, 8'h00, "unmapped read");
    $display("t_reset_values done");
  endtask : t_reset_values
  task automatic t_hard_reset;
    wr(sbx_pkg::SBX_ADDR_CONFIG, 8'h02);
    chk({rp_out, rp_oe}, 2'b01, "hard reset drives low");
    wr(sbx_pkg::SBX_ADDR_CONFIG, 8'h00);
    chk(rp_oe, 1'b0, "reset pin floats");
    // firmware enables the drive bus after power-up
    wr(sbx_pkg::SBX_ADDR_PKTLEN, 8'h00);
    chk({d_oe, rp_oe, rp_out}, 3'b111, "bus driven");
    $display("t_hard_reset done");
  endtask : t_hard_reset
  task automatic t_count_rw;
    wr(sbx_pkg::SBX_ADDR_COUNT3, 8'hA5);
    for (int s = 0; s < 2; s++)
    begin
      wr(sbx_pkg::SBX_ADDR_CONFIG, s[0] ? 8'h04 : 8'h00);
      rd(sbx_pkg::SBX_ADDR_COUNT3, rd_d);
      chk(rd_d, 8'hA5, "count3 copy");
    end
    // a write while the enable is low must leave the byte alone
    @(posedge core_clk);
    clk_en <= 1'b0;
    wr(sbx_pkg::SBX_ADDR_COUNT3, 8'h5A);
    @(posedge core_clk);
    clk_en <= 1'b1;
    rd(sbx_pkg::SBX_ADDR_COUNT3, rd_d);
    chk(rd_d, 8'hA5, "write frozen by enable");
    $display("t_count_rw done");
  endtask : t_count_rw
  task automatic t_decrement;
    wr(sbx_pkg::SBX_ADDR_COUNT0, 8'h10);
    @(posedge core_clk);
    host_dec_valid <= 1'b1;
    host_dec_bytes <= 16'h0004;
    drive_dec_valid <= 1'b1;
    drive_dec_bytes <= 16'h0002;
    @(posedge core_clk);
    host_dec_valid <= 1'b0;
    drive_dec_valid <= 1'b0;
    wr(sbx_pkg::SBX_ADDR_CONFIG, 8'h00);
    chk(h_cnt, 32'hA500_000C, "host count out");
    chk(d_cnt, 32'hA500_000E, "drive count out");
    rd(sbx_pkg::SBX_ADDR_COUNT0, rd_d);
    chk(rd_d, 8'h0C, "host copy");
    wr(sbx_pkg::SBX_ADDR_CONFIG, 8'h04);
    rd(sbx_pkg::SBX_ADDR_COUNT0, rd_d);
    chk(rd_d, 8'h0E, "drive copy");
    $display("t_decrement done");
  endtask : t_decrement
  task automatic t_cmd_phase;
    logic [7:0] cfg [0:5] = '{8'h29, 8'h29, 8'h29, 8'h29, 8'h21, 8'h28};
    logic [7:0] len [0:5] = '{8'h03, 8'h00, 8'h10, 8'h14, 8'h03, 8'h03};
    int         fst [0:5] = '{0, 0, 0, 0, 1, 0};
    int         num [0:5] = '{3, 0, 16, 16, 7, 0};
    int         k;
    for (int i = 0; i < 4; i++)
      wr(sbx_pkg::SBX_ADDR_COUNT0 + 16'(i), 8'h00);
    for (int i = 0; i < 6; i++)
    begin
      slow <= (i == 2);
      wr(sbx_pkg::SBX_ADDR_PKTLEN, len[i]);
      wr(sbx_pkg::SBX_ADDR_CONFIG, cfg[i]);
      clr <= 1'b1;
      start();
      clr <= 1'b0;
      k = 0;
      while (st !== 5'h00 && k < 300)
      begin
        @(posedge core_clk);
        #1;
        k++;
      end
      if (k == 300)
      begin
        errors++;
        end_of_test();
      end
      chk(n_rx, 6'(num[i]), "byte count");
      for (int b = 0; b < num[i]; b++)
        chk(rx_bytes[b], {4'h5, 4'(fst[i] + b)}, "command byte");
    end
    $display("t_cmd_phase done");
  endtask : t_cmd_phase
  task automatic t_abort;
    wr(sbx_pkg::SBX_ADDR_COUNT3, 8'h01);
    wr(sbx_pkg::SBX_ADDR_PKTLEN, 8'h20);
    wr(sbx_pkg::SBX_ADDR_CONFIG, 8'h10);
    start();
    chk(st, 5'h02, "data state with bus floating");
    wr(sbx_pkg::SBX_ADDR_PKTLEN, 8'h60);
    @(posedge core_clk);
    #1;
    chk(st, 5'h00, "abort idles");
    start();
    chk(st, 5'h00, "start refused under abort");
    // firmware sees idle before clearing the abort
    rd(sbx_pkg::SBX_ADDR_STATE, rd_d);
    chk(rd_d, 8'h00, "state reads idle");
    wr(sbx_pkg::SBX_ADDR_PKTLEN, 8'h20);
    start();
    chk(st, 5'h02, "start after clear");
    $display("t_abort done");
  endtask : t_abort
  // main sequence
  initial
  begin
    nrst = 1'b0;
    {reg_wr, reg_rd, xfer_start, clr, slow, host_dec_valid, drive_dec_valid} = 7'h00;
    clk_en = 1'b1;
    {reg_addr, reg_wdata, host_dec_bytes, drive_dec_bytes} = 56'h0;
    repeat (6) @(posedge core_clk);
    nrst <= 1'b1;
    t_reset_values();
    t_hard_reset();
    t_count_rw();
    t_decrement();
    t_cmd_phase();
    t_abort();
    end_of_test();
  end
endmodule : sbx_xfer_ctrl_test
